//--- inc/cpu_bus_pkg.sv
// Purpose: Shared constants for the asynchronous CPU bus port and its host
// Assumes: One clock at 20 MHz on both ends
// Notes:   Register indices are pointer values, not byte addresses
package cpu_bus_pkg;
  localparam int          CLK_PERIOD_NS   = 50;
  // Strobes low together this long request a hardware reset
  localparam int          RESET_WIDTH_NS  = 65;
  localparam int          RESET_CYC       = (RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least spacing between strobe falls of two accesses
  localparam int          RECOVERY_PCLKS  = 4;
  // Least delay from acknowledge level low to read strobe fall
  localparam int          ACK_SETTLE_NS   = 45;
  localparam int          ACK_SETTLE_CYC  = (ACK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host strobe length; covers both synchronisers and the data return
  localparam int          STROBE_CYC      = 8;
  localparam int          RESET_HOLD_CYC  = RESET_CYC + 3;

  localparam logic [3:0]  REG_CMD         = 4'h0;
  localparam logic [3:0]  REG_STATUS1     = 4'h1;
  localparam logic [3:0]  REG_VECTOR      = 4'h2;
  localparam logic [3:0]  REG_PENDING     = 4'h3;
  localparam logic [3:0]  REG_FCNT_LOW    = 4'h6;
  localparam logic [3:0]  REG_FCNT_HIGH   = 4'h7;
  localparam logic [3:0]  REG_INT_CTRL    = 4'h9;
  localparam logic [3:0]  REG_TC_LOW      = 4'hC;
  localparam logic [3:0]  REG_TC_HIGH     = 4'hD;
  localparam logic [3:0]  REG_FEATURE     = 4'hF;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;

  localparam int          FEAT_FIFO_EN    = 2;
  localparam int          INT_NO_VECTOR   = 1;
  localparam int          PTR_LSB         = 0;
  localparam int          CMD_LSB         = 3;
  localparam logic [2:0]  CMD_POINT_HIGH  = 3'h1;
  localparam logic [2:0]  CMD_RESET_IUS   = 3'h7;

  typedef enum logic [1:0] {
    KIND_READ  = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_ACK   = 2'h2,
    KIND_RESET = 2'h3
  } access_kind_e;
endpackage : cpu_bus_pkg

//--- inc/cpu_bus_if.sv
// Purpose: Pins between the CPU host and the serial controller bus port
// Assumes: Data bus floats high when nobody drives it
// Notes:   Host and device drive the data bus through separate enables
`timescale 1ns/10ps
`default_nettype none
interface cpu_bus_if;
  logic       ce_n;
  logic       rd_n;
  logic       wr_n;
  logic       vector_cycle_flag_n;
  logic       chan_b;
  logic       data_sel;
  logic [7:0] host_d;
  logic       host_d_oe;
  logic [7:0] dev_d;
  logic       dev_d_oe;
  logic [7:0] bus_d;
  logic       daisy_chain_in;
  logic       daisy_chain_out;
  logic       irq_n;

  assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 8'hFF);

  modport device (
    input  ce_n, rd_n, wr_n, vector_cycle_flag_n, chan_b, data_sel, bus_d, daisy_chain_in,
    output dev_d, dev_d_oe, daisy_chain_out, irq_n
  );
  modport host (
    input  bus_d, irq_n,
    output ce_n, rd_n, wr_n, vector_cycle_flag_n, chan_b, data_sel, host_d, host_d_oe
  );
endinterface : cpu_bus_if
`default_nettype wire

//--- src/cpu_bus_device.sv
// Purpose: Device end of the asynchronous CPU bus port of a dual serial controller
// Assumes: Bus pins are asynchronous to REF_CLK; user side is on REF_CLK
// Notes:   Channel A is index 0 and has the higher interrupt priority
// Notes on behaviour
// - Strobes pass two flops before use.
// - Host spaces strobe falls four clocks apart.
// - Spacing applies only between accesses here.
// - Host holds selects and acknowledge during cycle.
// - Read needs chip select and read low.
// - Write needs chip select and write low.
// - Write data captured late in cycle.
// - Host lets daisy chain settle before read.
// - Claim only with pending request, chain in high.
// - Claimed cycle drives vector unless disabled.
// - Claim sets matching in-service latch.
// - Frame count registers need feature bit two.
// - Pointer written first, then register accessed.
// - Pointer clears after the following control register access.
// - Data select high reaches data registers directly.
// - Both strobes long low means hardware reset.
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_device (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  cpu_bus_if.device        BUS,
  input  wire logic [15:0] RX_DATA,
  input  wire logic [15:0] STATUS0,
  input  wire logic [15:0] STATUS1,
  input  wire logic [31:0] FRAME_COUNT,
  input  wire logic [1:0]  IRQ_PENDING,
  output logic      [7:0]  TX_DATA,
  output logic             TX_STROBE,
  output logic             RX_TAKE,
  output logic             ACC_CHAN_B,
  output logic      [1:0]  IUS,
  output logic             SOFT_RESET,
  output logic      [1:0]  FIFO_EN
);
  // Sync bundle: {daisy, bus_d[7:0], data_sel, chan_b, ack_n, wr_n, rd_n, ce_n}
  logic [14:0] sync1_r;
  logic [14:0] sync2_r;
  logic        ce_s;
  logic        rd_s;
  logic        wr_s;
  logic        ack_s;
  logic        chan_s;
  logic        dsel_s;
  logic [7:0]  data_s;
  logic        daisy_s;
  logic        rd_act;
  logic        wr_act;
  logic        rd_prev_r;
  logic        wr_prev_r;
  logic        rd_start;
  logic        rd_end;
  logic        wr_end;
  logic [7:0]  wdata_r;
  logic        wchan_r;
  logic        wdsel_r;
  logic [3:0]  rst_cnt_r;
  logic        hw_reset;
  logic [3:0]  ptr_r;
  logic [7:0]  wreg_r [2][16];
  logic [7:0]  rd_mux;
  logic        claim;
  logic [7:0]  dev_d_r;
  logic        dev_oe_r;
  logic        dco_r;
  logic        irq_n_r;

  localparam int CMD_HI = cpu_bus_pkg::CMD_LSB + 2;

  function automatic logic slot(input logic [3:0] idx, input logic ch);
    // Vector and interrupt control are shared by both channels
    if (idx == cpu_bus_pkg::REG_VECTOR || idx == cpu_bus_pkg::REG_INT_CTRL) begin
      slot = 1'b0;
    end else begin
      slot = ch;
    end
  endfunction : slot

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_r <= 15'h7FFF;
      sync2_r <= 15'h7FFF;
    end else begin
      sync1_r <= {BUS.daisy_chain_in, BUS.bus_d, BUS.data_sel, BUS.chan_b,
                  BUS.vector_cycle_flag_n, BUS.wr_n, BUS.rd_n, BUS.ce_n};
      sync2_r <= sync1_r;
    end
  end

  assign ce_s    = sync2_r[0];
  assign rd_s    = sync2_r[1];
  assign wr_s    = sync2_r[2];
  assign ack_s   = sync2_r[3];
  assign chan_s  = sync2_r[4];
  assign dsel_s  = sync2_r[5];
  assign data_s  = sync2_r[13:6];
  assign daisy_s = sync2_r[14];

  // read needs both lows; acknowledge reads need no chip select
  assign rd_act   = !rd_s && wr_s && (!ce_s || !ack_s);
  assign wr_act   = !ce_s && !wr_s && rd_s;
  assign rd_start = rd_act && !rd_prev_r;
  assign rd_end   = !rd_act && rd_prev_r;
  assign wr_end   = !wr_act && wr_prev_r;
  assign claim    = rd_start && !ack_s && (|IRQ_PENDING) && daisy_s;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else begin
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wdata_r <= 8'h00;
      wchan_r <= 1'b0;
      wdsel_r <= 1'b0;
    end else if (wr_act) begin
      wdata_r <= data_s;
      wchan_r <= chan_s;
      wdsel_r <= dsel_s;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_cnt_r <= 4'h0;
    end else if (!rd_s && !wr_s) begin
      if (rst_cnt_r != 4'(cpu_bus_pkg::RESET_CYC)) begin
        rst_cnt_r <= rst_cnt_r + 4'h1;
      end
    end else begin
      rst_cnt_r <= 4'h0;
    end
  end
  assign hw_reset = !rd_s && !wr_s && (rst_cnt_r == 4'(cpu_bus_pkg::RESET_CYC - 1));

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      SOFT_RESET <= 1'b0;
    end else begin
      SOFT_RESET <= hw_reset;
    end
  end

  // Read multiplexer for control registers
  always_comb begin
    rd_mux = 8'h00;
    if (ptr_r == cpu_bus_pkg::REG_CMD) begin
      rd_mux = chan_s ? STATUS0[15:8] : STATUS0[7:0];
    end else if (ptr_r == cpu_bus_pkg::REG_STATUS1) begin
      rd_mux = chan_s ? STATUS1[15:8] : STATUS1[7:0];
    end else if (ptr_r == cpu_bus_pkg::REG_VECTOR) begin
      rd_mux = wreg_r[0][cpu_bus_pkg::REG_VECTOR];
    end else if (ptr_r == cpu_bus_pkg::REG_PENDING) begin
      rd_mux = chan_s ? 8'h00 : {6'h00, IRQ_PENDING};
    end else if (ptr_r == cpu_bus_pkg::REG_FCNT_LOW) begin
      if (wreg_r[chan_s][cpu_bus_pkg::REG_FEATURE][cpu_bus_pkg::FEAT_FIFO_EN]) begin
        rd_mux = chan_s ? FRAME_COUNT[23:16] : FRAME_COUNT[7:0];
      end else begin
        rd_mux = wreg_r[0][cpu_bus_pkg::REG_VECTOR];
      end
    end else if (ptr_r == cpu_bus_pkg::REG_FCNT_HIGH) begin
      if (wreg_r[chan_s][cpu_bus_pkg::REG_FEATURE][cpu_bus_pkg::FEAT_FIFO_EN]) begin
        rd_mux = chan_s ? FRAME_COUNT[31:24] : FRAME_COUNT[15:8];
      end else begin
        rd_mux = chan_s ? 8'h00 : {6'h00, IRQ_PENDING};
      end
    end else if (ptr_r == cpu_bus_pkg::REG_TC_LOW || ptr_r == cpu_bus_pkg::REG_TC_HIGH
                 || ptr_r == cpu_bus_pkg::REG_FEATURE) begin
      rd_mux = wreg_r[chan_s][ptr_r];
    end
  end

  // Pointer, write registers and data register strobes
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ptr_r <= 4'h0;
      for (int c = 0; c < 2; c++) begin
        for (int r = 0; r < 16; r++) begin
          wreg_r[c][r] <= cpu_bus_pkg::REG_RESET_VAL;
        end
      end
    end else if (hw_reset) begin
      ptr_r <= 4'h0;
      for (int c = 0; c < 2; c++) begin
        for (int r = 0; r < 16; r++) begin
          wreg_r[c][r] <= cpu_bus_pkg::REG_RESET_VAL;
        end
      end
    end else if (wr_end && !wdsel_r) begin
      if (ptr_r == cpu_bus_pkg::REG_CMD) begin
        ptr_r <= {wdata_r[CMD_HI:cpu_bus_pkg::CMD_LSB] == cpu_bus_pkg::CMD_POINT_HIGH,
                  wdata_r[cpu_bus_pkg::PTR_LSB +: 3]};
      end else begin
        wreg_r[slot(ptr_r, wchan_r)][ptr_r] <= wdata_r;
        ptr_r <= 4'h0;
      end
    end else if (rd_start && ack_s && !dsel_s && ptr_r != cpu_bus_pkg::REG_CMD) begin
      ptr_r <= 4'h0;
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      TX_DATA    <= 8'h00;
      TX_STROBE  <= 1'b0;
      RX_TAKE    <= 1'b0;
      ACC_CHAN_B <= 1'b0;
    end else begin
      TX_STROBE <= wr_end && wdsel_r;
      RX_TAKE   <= rd_start && ack_s && dsel_s;
      if (wr_end && wdsel_r) begin
        TX_DATA    <= wdata_r;
        ACC_CHAN_B <= wchan_r;
      end else if (rd_start && ack_s && dsel_s) begin
        ACC_CHAN_B <= chan_s;
      end
    end
  end

  // Data bus drive during reads and claimed acknowledge cycles
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      dev_d_r  <= 8'h00;
      dev_oe_r <= 1'b0;
    end else if (rd_end || hw_reset) begin
      dev_oe_r <= 1'b0;
    end else if (claim) begin
      dev_d_r  <= wreg_r[0][cpu_bus_pkg::REG_VECTOR];
      dev_oe_r <= !wreg_r[0][cpu_bus_pkg::REG_INT_CTRL][cpu_bus_pkg::INT_NO_VECTOR];
    end else if (rd_start && ack_s) begin
      dev_d_r  <= dsel_s ? (chan_s ? RX_DATA[15:8] : RX_DATA[7:0]) : rd_mux;
      dev_oe_r <= 1'b1;
    end
  end

  // In-service latches
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      IUS <= 2'h0;
    end else if (hw_reset) begin
      IUS <= 2'h0;
    end else if (claim) begin
      IUS <= IUS | (IRQ_PENDING[0] ? 2'h1 : 2'h2);
    end else if (wr_end && !wdsel_r && ptr_r == cpu_bus_pkg::REG_CMD
                 && wdata_r[CMD_HI:cpu_bus_pkg::CMD_LSB] == cpu_bus_pkg::CMD_RESET_IUS) begin
      IUS <= IUS[0] ? {IUS[1], 1'b0} : 2'h0;
    end
  end

  // Interrupt request and daisy chain out
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_n_r <= 1'b1;
      dco_r   <= 1'b0;
    end else begin
      irq_n_r <= !((|IRQ_PENDING) && daisy_s && !(|IUS));
      dco_r   <= daisy_s && !(|IUS) && !(!ack_s && (|IRQ_PENDING));
    end
  end

  assign FIFO_EN             = {wreg_r[1][cpu_bus_pkg::REG_FEATURE][cpu_bus_pkg::FEAT_FIFO_EN],
                                wreg_r[0][cpu_bus_pkg::REG_FEATURE][cpu_bus_pkg::FEAT_FIFO_EN]};
  assign BUS.dev_d           = dev_d_r;
  assign BUS.dev_d_oe        = dev_oe_r;
  assign BUS.irq_n           = irq_n_r;
  assign BUS.daisy_chain_out = dco_r;
endmodule : cpu_bus_device
`default_nettype wire

//--- src/cpu_bus_host.sv
// Purpose: CPU end that runs read, write, acknowledge and reset cycles on the bus
// Assumes: Only this device sits on the bus, so every cycle counts for spacing
// Notes:   One request at a time; READY high means a request can be taken
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_host (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  cpu_bus_if.host          BUS,
  input  wire logic        REQ,
  input  wire logic [1:0]  REQ_KIND,
  input  wire logic        REQ_CHAN_B,
  input  wire logic        REQ_DATA_SEL,
  input  wire logic [7:0]  REQ_WDATA,
  output logic             READY,
  output logic             DONE,
  output logic      [7:0]  RDATA
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_GAP    = 3'b110
  } host_state_e;

  host_state_e  state_r;
  logic [3:0]   cnt_r;
  logic [3:0]   rec_r;
  logic [7:0]   d_s1_r;
  logic [7:0]   d_s2_r;
  logic [1:0]   kind_r;
  logic         ce_n_r;
  logic         rd_n_r;
  logic         wr_n_r;
  logic         ack_n_r;
  logic         chan_r;
  logic         dsel_r;
  logic [7:0]   wd_r;
  logic         d_oe_r;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      d_s1_r <= 8'hFF;
      d_s2_r <= 8'hFF;
    end else begin
      d_s1_r <= BUS.bus_d;
      d_s2_r <= d_s1_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rec_r <= 4'h0;
    end else if (state_r == ST_SETUP && cnt_r == 4'h0 && rec_r == 4'h0) begin
      rec_r <= 4'(cpu_bus_pkg::RECOVERY_PCLKS - 1);
    end else if (rec_r != 4'h0) begin
      rec_r <= rec_r - 4'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      kind_r  <= 2'h0;
      ce_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      wr_n_r  <= 1'b1;
      ack_n_r <= 1'b1;
      chan_r  <= 1'b0;
      dsel_r  <= 1'b0;
      wd_r    <= 8'h00;
      d_oe_r  <= 1'b0;
      READY   <= 1'b1;
      DONE    <= 1'b0;
      RDATA   <= 8'h00;
    end else begin
      DONE <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (REQ) begin
            kind_r  <= REQ_KIND;
            chan_r  <= REQ_CHAN_B;
            dsel_r  <= REQ_DATA_SEL;
            wd_r    <= REQ_WDATA;
            d_oe_r  <= REQ_KIND == cpu_bus_pkg::KIND_WRITE;
            ack_n_r <= REQ_KIND != cpu_bus_pkg::KIND_ACK;
            ce_n_r  <= REQ_KIND == cpu_bus_pkg::KIND_ACK;
            cnt_r   <= (REQ_KIND == cpu_bus_pkg::KIND_ACK) ?
                       4'(cpu_bus_pkg::ACK_SETTLE_CYC) : 4'h0;
            READY   <= 1'b0;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (rec_r == 4'h0) begin
            rd_n_r  <= kind_r == cpu_bus_pkg::KIND_WRITE;
            wr_n_r  <= kind_r == cpu_bus_pkg::KIND_READ || kind_r == cpu_bus_pkg::KIND_ACK;
            cnt_r   <= (kind_r == cpu_bus_pkg::KIND_RESET) ?
                       4'(cpu_bus_pkg::RESET_HOLD_CYC - 1) : 4'(cpu_bus_pkg::STROBE_CYC - 1);
            state_r <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            RDATA   <= d_s2_r;
            rd_n_r  <= 1'b1;
            wr_n_r  <= 1'b1;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          ce_n_r  <= 1'b1;
          ack_n_r <= 1'b1;
          d_oe_r  <= 1'b0;
          state_r <= ST_GAP;
        end
        ST_GAP: begin
          DONE    <= 1'b1;
          READY   <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign BUS.ce_n                = ce_n_r;
  assign BUS.rd_n                = rd_n_r;
  assign BUS.wr_n                = wr_n_r;
  assign BUS.vector_cycle_flag_n = ack_n_r;
  assign BUS.chan_b              = chan_r;
  assign BUS.data_sel            = dsel_r;
  assign BUS.host_d              = wd_r;
  assign BUS.host_d_oe           = d_oe_r;
endmodule : cpu_bus_host
`default_nettype wire

//--- verif/cpu_bus_monitor.sv
// Purpose: Concurrent checks on the pins between host end and device end
// Assumes: One clock for both ends; NRST asynchronous, active low
// Notes:   Sees only the interface signals
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_monitor (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic ce_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic vector_cycle_flag_n,
  input wire logic chan_b,
  input wire logic data_sel,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  input wire logic daisy_chain_in,
  input wire logic daisy_chain_out,
  input wire logic irq_n
);
  logic rd_act;

  // Read as the device may see it: strobe low, selected or acknowledging, no write
  assign rd_act = !rd_n && wr_n && (!ce_n || !vector_cycle_flag_n);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence s_strobe_fall;
    $fell(rd_n) || $fell(wr_n);
  endsequence
  sequence s_ack_fall;
    $fell(vector_cycle_flag_n);
  endsequence

  property p_recovery;
    s_strobe_fall |=> (!($fell(rd_n) || $fell(wr_n)))[*3];
  endproperty
  property p_select_hold;
    (!rd_n || !wr_n) && $past(!rd_n || !wr_n) |->
      $stable(chan_b) && $stable(data_sel) && $stable(vector_cycle_flag_n);
  endproperty
  property p_drive_needs_read;
    dev_d_oe |-> $past(rd_act, 2) || $past(rd_act, 3) || $past(rd_act, 4);
  endproperty
  property p_release;
    $rose(rd_n) |-> ##[1:4] !dev_d_oe;
  endproperty
  property p_write_drive;
    !wr_n && rd_n |-> host_d_oe && !dev_d_oe;
  endproperty
  property p_ack_settle;
    s_ack_fall |-> rd_n ##1 rd_n;
  endproperty
  property p_no_claim;
    !vector_cycle_flag_n && !daisy_chain_in |-> !dev_d_oe;
  endproperty
  property p_chain_blocks;
    (!daisy_chain_in)[*4] |-> !daisy_chain_out;
  endproperty
  property p_claim_drops_irq;
    !vector_cycle_flag_n && $rose(dev_d_oe) |-> ##[0:2] irq_n;
  endproperty

  a_recovery: assert property (p_recovery)
    else $error("strobe falls closer than four clocks");
  a_select_hold: assert property (p_select_hold)
    else $error("select changed inside a cycle");
  a_drive_needs_read: assert property (p_drive_needs_read)
    else $error("device drives data without a read");
  a_release: assert property (p_release)
    else $error("device kept data bus after read end");
  a_write_drive: assert property (p_write_drive)
    else $error("wrong data driver during write");
  a_ack_settle: assert property (p_ack_settle)
    else $error("read strobe too soon after acknowledge");
  a_no_claim: assert property (p_no_claim)
    else $error("acknowledge claimed with chain input low");
  a_chain_blocks: assert property (p_chain_blocks)
    else $error("chain output high while chain input low");
  a_claim_drops_irq: assert property (p_claim_drops_irq)
    else $error("request still low after claim");
endmodule : cpu_bus_monitor
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Host end and device end joined; user-side read, write and acknowledge tests
// Assumes: Host holds cycle spacing; bench plays daisy chain input
// Notes:   Checks are made after the following access where the device updates late
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        ref_clk;
  logic        nrst;
  logic        req;
  logic [1:0]  req_kind;
  logic        req_chan_b;
  logic        req_data_sel;
  logic [7:0]  req_wdata;
  logic        ready;
  logic        done;
  logic [7:0]  rdata;
  logic [15:0] rx_data;
  logic [15:0] status0;
  logic [15:0] status1;
  logic [31:0] frame_count;
  logic [1:0]  irq_pending;
  logic [7:0]  tx_data;
  logic        tx_strobe;
  logic        rx_take;
  logic        acc_chan_b;
  logic [1:0]  ius;
  logic        soft_reset;
  logic [1:0]  fifo_en;
  logic        chain_in;
  logic [7:0]  tx_last;
  int          num_errors;
  int          comparisons;
  int          resets_seen;
  int          rx_seen;

  cpu_bus_if bus_if ();
  assign bus_if.daisy_chain_in = chain_in;

  cpu_bus_host u_cpu_bus_host (.REF_CLK(ref_clk), .NRST(nrst), .BUS(bus_if), .REQ(req),
    .REQ_KIND(req_kind), .REQ_CHAN_B(req_chan_b), .REQ_DATA_SEL(req_data_sel),
    .REQ_WDATA(req_wdata), .READY(ready), .DONE(done), .RDATA(rdata));
  cpu_bus_device u_cpu_bus_device (.REF_CLK(ref_clk), .NRST(nrst), .BUS(bus_if),
    .RX_DATA(rx_data), .STATUS0(status0), .STATUS1(status1), .FRAME_COUNT(frame_count),
    .IRQ_PENDING(irq_pending), .TX_DATA(tx_data), .TX_STROBE(tx_strobe), .RX_TAKE(rx_take),
    .ACC_CHAN_B(acc_chan_b), .IUS(ius), .SOFT_RESET(soft_reset), .FIFO_EN(fifo_en));
  cpu_bus_monitor u_cpu_bus_monitor (.REF_CLK(ref_clk), .NRST(nrst), .ce_n(bus_if.ce_n),
    .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .vector_cycle_flag_n(bus_if.vector_cycle_flag_n),
    .chan_b(bus_if.chan_b), .data_sel(bus_if.data_sel), .host_d_oe(bus_if.host_d_oe),
    .dev_d_oe(bus_if.dev_d_oe), .daisy_chain_in(bus_if.daisy_chain_in),
    .daisy_chain_out(bus_if.daisy_chain_out), .irq_n(bus_if.irq_n));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Capture pulse-qualified outputs mid-cycle
  always @(negedge ref_clk) begin
    if (tx_strobe === 1'b1) tx_last = tx_data;
    if (soft_reset === 1'b1) resets_seen++;
    if (rx_take === 1'b1) rx_seen++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic access(input logic [1:0] kind, input logic chb, input logic ds,
                        input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    #2;
    req = 1'b1;
    req_kind = kind;
    req_chan_b = chb;
    req_data_sel = ds;
    req_wdata = wd;
    @(posedge ref_clk);
    #2;
    req = 1'b0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      $display("ERROR at %0t ns: no completion", $time);
    end
  endtask : access

  task automatic wr_reg(input logic chb, input logic [3:0] idx, input logic [7:0] val);
    if (idx != cpu_bus_pkg::REG_CMD)
      access(cpu_bus_pkg::KIND_WRITE, chb, 1'b0,
             {2'b00, idx[3] ? cpu_bus_pkg::CMD_POINT_HIGH : 3'h0, idx[2:0]});
    access(cpu_bus_pkg::KIND_WRITE, chb, 1'b0, val);
  endtask : wr_reg

  task automatic rd_reg(input logic chb, input logic [3:0] idx, output logic [7:0] val);
    if (idx != cpu_bus_pkg::REG_CMD)
      access(cpu_bus_pkg::KIND_WRITE, chb, 1'b0,
             {2'b00, idx[3] ? cpu_bus_pkg::CMD_POINT_HIGH : 3'h0, idx[2:0]});
    access(cpu_bus_pkg::KIND_READ, chb, 1'b0, 8'h00);
    val = rdata;
  endtask : rd_reg

  task automatic summarize();
    $display("Counts: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #(3000 * 50);
    num_errors++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    summarize();
  end

  initial begin
    logic [7:0] v;
    nrst = 1'b0;
    req = 1'b0;
    req_kind = 2'h0;
    req_chan_b = 1'b0;
    req_data_sel = 1'b0;
    req_wdata = 8'h00;
    rx_data = 16'hB4A5;
    status0 = 16'h6A39;
    status1 = 16'hC7E1;
    frame_count = 32'h5D2E_9B17;
    irq_pending = 2'b00;
    chain_in = 1'b1;
    num_errors = 0;
    comparisons = 0;
    resets_seen = 0;
    rx_seen = 0;
    repeat (8) @(posedge ref_clk);
    #2;
    nrst = 1'b1;
    // Data registers reached directly, channel split
    access(cpu_bus_pkg::KIND_READ, 1'b1, 1'b1, 8'h00);
    chk(rdata, 8'hB4, "data read B");
    chk({7'h00, acc_chan_b}, 8'h01, "read channel B");
    access(cpu_bus_pkg::KIND_WRITE, 1'b0, 1'b1, 8'h5C);
    rd_reg(1'b0, cpu_bus_pkg::REG_STATUS1, v);
    chk(tx_last, 8'h5C, "data write A");
    chk({7'h00, acc_chan_b}, 8'h00, "write channel");
    chk(v, status1[7:0], "pointer read A");
    access(cpu_bus_pkg::KIND_READ, 1'b0, 1'b0, 8'h00);
    chk(rdata, status0[7:0], "pointer cleared");
    rd_reg(1'b1, cpu_bus_pkg::REG_STATUS1, v);
    chk(v, status1[15:8], "pointer read B");
    access(cpu_bus_pkg::KIND_READ, 1'b0, 1'b1, 8'h00);
    chk(rdata, 8'hA5, "data read A");
    chk(8'(rx_seen), 8'h02, "data reads taken");
    $display("Scenario data and pointer finished");
    // Frame counts hidden until the feature bit is set
    wr_reg(1'b0, cpu_bus_pkg::REG_VECTOR, 8'h3C);
    rd_reg(1'b0, cpu_bus_pkg::REG_FCNT_LOW, v);
    chk(v, 8'h3C, "count low gated");
    rd_reg(1'b0, cpu_bus_pkg::REG_FCNT_HIGH, v);
    chk(v, 8'h00, "count high gated");
    wr_reg(1'b0, cpu_bus_pkg::REG_FEATURE, 8'h01 << cpu_bus_pkg::FEAT_FIFO_EN);
    rd_reg(1'b0, cpu_bus_pkg::REG_FCNT_LOW, v);
    chk(v, frame_count[7:0], "count low open");
    chk({6'h00, fifo_en}, 8'h01, "feature bit");
    rd_reg(1'b0, cpu_bus_pkg::REG_FCNT_HIGH, v);
    chk(v, frame_count[15:8], "count high open");
    chk({7'h00, bus_if.daisy_chain_out}, 8'h01, "chain out passes");
    $display("Scenario frame count finished");
    // Acknowledge: refused with chain low, claimed with chain high
    irq_pending = 2'b01;
    chain_in = 1'b0;
    access(cpu_bus_pkg::KIND_ACK, 1'b0, 1'b0, 8'h00);
    chk(rdata, 8'hFF, "ack unclaimed data");
    chk({6'h00, ius}, 8'h00, "ack unclaimed latch");
    chk({7'h00, bus_if.daisy_chain_out}, 8'h00, "chain out blocked");
    chain_in = 1'b1;
    access(cpu_bus_pkg::KIND_ACK, 1'b0, 1'b0, 8'h00);
    chk(rdata, 8'h3C, "ack vector");
    chk({6'h00, ius}, 8'h01, "ack latch A");
    chk({7'h00, bus_if.irq_n}, 8'h01, "request served");
    wr_reg(1'b0, cpu_bus_pkg::REG_CMD, {2'b00, cpu_bus_pkg::CMD_RESET_IUS, 3'h0});
    wr_reg(1'b0, cpu_bus_pkg::REG_INT_CTRL, 8'h01 << cpu_bus_pkg::INT_NO_VECTOR);
    chk({6'h00, ius}, 8'h00, "latch cleared");
    irq_pending = 2'b10;
    access(cpu_bus_pkg::KIND_ACK, 1'b0, 1'b0, 8'h00);
    chk(rdata, 8'hFF, "vector suppressed");
    chk({6'h00, ius}, 8'h02, "ack latch B");
    $display("Scenario acknowledge finished");
    // Both strobes low together reset the device
    access(cpu_bus_pkg::KIND_RESET, 1'b0, 1'b0, 8'h00);
    rd_reg(1'b0, cpu_bus_pkg::REG_VECTOR, v);
    chk(v, cpu_bus_pkg::REG_RESET_VAL, "vector after reset");
    chk({6'h00, fifo_en}, 8'h00, "feature after reset");
    chk(8'(resets_seen), 8'h01, "reset pulses");
    $display("Scenario hardware reset finished");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
